// ==== rtl/gtm_timer.sv ====
/*
  Gated 16-bit timer/counter with clock source select, prescaler,
  gate polarity, toggle and single-pulse modes, behind an APB slave.
  Assumes pclk is the system clock; all sources arrive as asynchronous
  levels and are sampled on pclk.
*/
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns

module gtm_timer #(
  parameter bit HAS_OSC = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_input,
  input  wire logic        crystal_in_pin,
  input  wire logic        low_freq_internal_oscillator,
  input  wire logic        gate_pin,
  input  wire logic        tmr8_overflow,
  input  wire logic        cmp_a_output,
  input  wire logic        cmp_b_output,
  output logic             crystal_out_pin,
  output logic             crystal_osc_on,
  output logic             rollover_flag,
  output logic             gate_event_flag
);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [7:0]  timer_control;
  logic [7:0]  gate_control;
  logic [15:0] count;
  logic [6:0]  raw_in;
  logic [6:0]  sync_in;
  logic        src_ext;
  logic        src_xtal;
  logic        src_lfo;
  logic        src_gpin;
  logic        src_t8;
  logic        src_ca;
  logic        src_cb;
  logic [1:0]  quarter_cnt;
  logic        quarter_tick;
  logic        ext_prev;
  logic        ext_prev2;
  logic        src_level;
  logic        src_rise;
  logic        clk_tick;
  logic [2:0]  ps_cnt;
  logic        ps_tick;
  logic        gate_raw;
  logic        gate_prev;
  logic        toggle_ff;
  logic        gate_tog;
  logic        gate_pol;
  logic        gate_pol_prev;
  logic        spm_window;
  logic        gate_level;
  logic        gate_level_prev;
  logic        count_ok;
  logic        incr;
  logic        apb_wr;
  logic        apb_rd;
  logic        arm_wr_set;
  logic        flag_clr_roll;
  logic        flag_clr_gate;
  logic        osc_allowed;

  // ----------------------------------------------------------------------
  // Input synchronisation.
  // ----------------------------------------------------------------------

  // Every pin-level source passes two flops before any logic sees it.
  assign raw_in = {cmp_b_output, cmp_a_output, tmr8_overflow, gate_pin,
                   low_freq_internal_oscillator, crystal_in_pin, ext_count_input};

  gtm_sync2 #(
    .W (7)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw_in),
    .q       (sync_in)
  );

  assign src_ext  = sync_in[0];
  assign src_xtal = sync_in[1];
  assign src_lfo  = sync_in[2];
  assign src_gpin = sync_in[3];
  assign src_t8   = sync_in[4];
  assign src_ca   = sync_in[5];
  assign src_cb   = sync_in[6];

  // The crystal option exists only on the first instance.
  assign osc_allowed = HAS_OSC & timer_control[gtm_pkg::TC_OSC_EN];

  // ----------------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------------
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;

  // Software writes to the arm bit and one-to-clear flag bits.
  assign arm_wr_set    = apb_wr && (paddr == gtm_pkg::OFS_GATE_CONTROL)
                         && pwdata[gtm_pkg::GC_ARM];
  assign flag_clr_roll = apb_wr && (paddr == gtm_pkg::OFS_FLAGS)
                         && pwdata[gtm_pkg::FL_ROLLOVER];
  assign flag_clr_gate = apb_wr && (paddr == gtm_pkg::OFS_FLAGS)
                         && pwdata[gtm_pkg::FL_GATE_EV];

  // The slave answers in the access cycle; read data registered at setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > gtm_pkg::OFS_FLAGS);
    end
  end

  // Read multiplexer, captured during the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      if (paddr == gtm_pkg::OFS_TIMER_CONTROL) begin
        prdata <= {24'h000000, timer_control};
      end else if (paddr == gtm_pkg::OFS_GATE_CONTROL) begin
        prdata <= {24'h000000, gate_control[7:3], gate_level, gate_control[1:0]};
      end else if (paddr == gtm_pkg::OFS_COUNT_LOW) begin
        prdata <= {24'h000000, count[7:0]};
      end else if (paddr == gtm_pkg::OFS_COUNT_HIGH) begin
        prdata <= {24'h000000, count[15:8]};
      end else if (paddr == gtm_pkg::OFS_FLAGS) begin
        prdata <= {30'h0000_0000, gate_event_flag, rollover_flag};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------

  // Timer control; bit 1 is unimplemented and stays zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control <= gtm_pkg::CTRL_RESET;
    end else if (apb_wr && (paddr == gtm_pkg::OFS_TIMER_CONTROL)) begin
      timer_control <= pwdata[7:0] & gtm_pkg::TC_WMASK;
    end
  end

  // Gate control; arm bit is set by software and cleared by hardware.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_control <= gtm_pkg::CTRL_RESET;
    end else begin
      if (apb_wr && (paddr == gtm_pkg::OFS_GATE_CONTROL)) begin
        gate_control[7:4] <= pwdata[7:4];
        gate_control[1:0] <= pwdata[1:0];
      end
      gate_control[2] <= 1'b0;
      if (arm_wr_set && !gate_control[gtm_pkg::GC_ARM]) begin
        gate_control[gtm_pkg::GC_ARM] <= 1'b1;
      end else if (gate_control[gtm_pkg::GC_ARM] && gate_pol_prev && !gate_pol) begin
        gate_control[gtm_pkg::GC_ARM] <= 1'b0;
      end else if (!gate_control[gtm_pkg::GC_SPM]) begin
        gate_control[gtm_pkg::GC_ARM] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Count clock selection and prescaler.
  // ----------------------------------------------------------------------

  // Divide-by-four tick stands in for the instruction clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quarter_cnt <= 2'h0;
    end else begin
      quarter_cnt <= quarter_cnt + 2'h1;
    end
  end
  assign quarter_tick = (quarter_cnt == gtm_pkg::QUARTER_DIV);

  // Level of the selected asynchronous source.
  always_comb begin
    case (timer_control[7:6])
      gtm_pkg::CS_EXT:   src_level = osc_allowed ? src_xtal : src_ext;
      gtm_pkg::CS_LFOSC: src_level = src_lfo;
      default:           src_level = 1'b0;
    endcase
  end

  // An extra resync stage is applied unless the no-sync bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev  <= 1'b0;
      ext_prev2 <= 1'b0;
    end else begin
      ext_prev  <= src_level;
      ext_prev2 <= ext_prev;
    end
  end
  assign src_rise = timer_control[gtm_pkg::TC_NOSYNC] ? (src_level & ~ext_prev)
                                                     : (ext_prev & ~ext_prev2);

  // One tick per edge of the chosen count clock.
  always_comb begin
    case (timer_control[7:6])
      gtm_pkg::CS_INSTR: clk_tick = quarter_tick;
      gtm_pkg::CS_SYS:   clk_tick = 1'b1;
      default:           clk_tick = src_rise;
    endcase
  end

  // Prescaler counts count-clock ticks; cleared while stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt <= 3'h0;
    end else if (!timer_control[gtm_pkg::TC_RUN]) begin
      ps_cnt <= 3'h0;
    end else if (clk_tick && count_ok) begin
      ps_cnt <= ps_tick ? 3'h0 : ps_cnt + 3'h1;
    end
  end

  // Terminal count per prescale code: divide by 1, 2, 4 or 8.
  always_comb begin
    case (timer_control[5:4])
      2'h0:    ps_tick = 1'b1;
      2'h1:    ps_tick = (ps_cnt == 3'h1);
      2'h2:    ps_tick = (ps_cnt == 3'h3);
      default: ps_tick = (ps_cnt == 3'h7);
    endcase
  end

  // ----------------------------------------------------------------------
  // Gate path.
  // ----------------------------------------------------------------------

  // Gate source selection.
  always_comb begin
    case (gate_control[1:0])
      2'h0:    gate_raw = src_gpin;
      2'h1:    gate_raw = src_t8;
      2'h2:    gate_raw = src_ca;
      default: gate_raw = src_cb;
    endcase
  end

  // Toggle flop: toggles on rising gate edges, held clear when off or stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_prev <= 1'b0;
      toggle_ff <= 1'b0;
    end else begin
      gate_prev <= gate_raw;
      if (!gate_control[gtm_pkg::GC_TOGGLE] || !timer_control[gtm_pkg::TC_RUN]) begin
        toggle_ff <= 1'b0;
      end else if (gate_raw && !gate_prev) begin
        toggle_ff <= ~toggle_ff;
      end
    end
  end

  assign gate_tog = gate_control[gtm_pkg::GC_TOGGLE] ? toggle_ff : gate_raw;
  assign gate_pol = gate_control[gtm_pkg::GC_POL] ? gate_tog : ~gate_tog;

  // Single-pulse window opens on the active edge after arming.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_pol_prev <= 1'b0;
      spm_window    <= 1'b0;
    end else begin
      gate_pol_prev <= gate_pol;
      if (!gate_control[gtm_pkg::GC_ARM]) begin
        spm_window <= 1'b0;
      end else if (gate_pol && !gate_pol_prev) begin
        spm_window <= 1'b1;
      end
    end
  end

  // Gate level as it would reach the counter, independent of enable.
  assign gate_level = gate_control[gtm_pkg::GC_SPM] ? (spm_window & gate_pol)
                                                   : gate_pol;

  // Counting permission from run and gate enable.
  assign count_ok = timer_control[gtm_pkg::TC_RUN]
                    && (!gate_control[gtm_pkg::GC_ENABLE] || gate_level);
  assign incr     = clk_tick && count_ok && ps_tick;

  // ----------------------------------------------------------------------
  // Counter and flags.
  // ----------------------------------------------------------------------

  // Byte writes take precedence over counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= gtm_pkg::COUNT_RESET;
    end else if (apb_wr && (paddr == gtm_pkg::OFS_COUNT_LOW)) begin
      count[7:0] <= pwdata[7:0];
    end else if (apb_wr && (paddr == gtm_pkg::OFS_COUNT_HIGH)) begin
      count[15:8] <= pwdata[7:0];
    end else if (incr) begin
      count <= count + 16'h0001;
    end
  end

  // Sticky flags; a new event wins over a same-cycle clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_level_prev <= 1'b0;
      rollover_flag   <= 1'b0;
      gate_event_flag <= 1'b0;
    end else begin
      gate_level_prev <= gate_level;
      if (incr && (count == gtm_pkg::COUNT_MAX)) begin
        rollover_flag <= 1'b1;
      end else if (flag_clr_roll) begin
        rollover_flag <= 1'b0;
      end
      if (gate_level_prev && !gate_level) begin
        gate_event_flag <= 1'b1;
      end else if (flag_clr_gate) begin
        gate_event_flag <= 1'b0;
      end
    end
  end

  // Oscillator enable and feedback drive, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_osc_on  <= 1'b0;
      crystal_out_pin <= 1'b0;
    end else begin
      crystal_osc_on  <= osc_allowed;
      crystal_out_pin <= osc_allowed & ~src_xtal;
    end
  end

endmodule : gtm_timer

// ==== rtl/gtm_pkg.sv ====
/*
  Package for the gated 16-bit timer: register offsets, field positions,
  reset values and encodings.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package gtm_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_GATE_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW     = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH    = 8'h0C;
  localparam logic [7:0] OFS_FLAGS         = 8'h10;

  // ----------------------------------------------------------------------
  // Timer control fields.
  // ----------------------------------------------------------------------
  localparam int TC_RUN      = 0;
  localparam int TC_NOSYNC   = 2;
  localparam int TC_OSC_EN   = 3;
  localparam int TC_PS_LO    = 4;
  localparam int TC_CS_LO    = 6;
  localparam logic [7:0] TC_WMASK = 8'hFD;

  // ----------------------------------------------------------------------
  // Gate control fields.
  // ----------------------------------------------------------------------
  localparam int GC_GSS_LO   = 0;
  localparam int GC_LEVEL    = 2;
  localparam int GC_ARM      = 3;
  localparam int GC_SPM      = 4;
  localparam int GC_TOGGLE   = 5;
  localparam int GC_POL      = 6;
  localparam int GC_ENABLE   = 7;
  localparam logic [7:0] GC_WMASK = 8'hFB;

  // ----------------------------------------------------------------------
  // Flag register fields (write one to clear).
  // ----------------------------------------------------------------------
  localparam int FL_ROLLOVER = 0;
  localparam int FL_GATE_EV  = 1;

  // ----------------------------------------------------------------------
  // Reset values and encodings.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [1:0]  CS_INSTR    = 2'h0;
  localparam logic [1:0]  CS_SYS      = 2'h1;
  localparam logic [1:0]  CS_EXT      = 2'h2;
  localparam logic [1:0]  CS_LFOSC    = 2'h3;
  localparam logic [1:0]  QUARTER_DIV = 2'h3;

endpackage : gtm_pkg

// ==== rtl/gtm_sync2.sv ====
/*
  Two-flop synchroniser for a group of single-bit levels.
  Assumes inputs from outside the pclk domain; first stage feeds only the
  second.
*/
`timescale 1ns/1ns
module gtm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  // Two flops in series; only the second stage is visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : gtm_sync2

// ==== dv/gtm_timer_monitor.sv ====
/*
  Checker for the gated timer: bus answer timing, refusals and flags.
  Assumes it is bound to gtm_timer and sees only its ports.
*/
`timescale 1ns/1ns
module gtm_timer_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_count_input,
  input wire logic        crystal_in_pin,
  input wire logic        low_freq_internal_oscillator,
  input wire logic        gate_pin,
  input wire logic        tmr8_overflow,
  input wire logic        cmp_a_output,
  input wire logic        cmp_b_output,
  input wire logic        crystal_out_pin,
  input wire logic        crystal_osc_on,
  input wire logic        rollover_flag,
  input wire logic        gate_event_flag
);
  // ----------------------------------------------------------------------
  // Helpers and properties.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic fl_wr;
  // A completed write and a write to the flag word.
  assign wr_acc = psel && penable && pwrite;
  assign fl_wr  = wr_acc && (paddr == 8'h10);

  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held too long");
  property p_err_map; pready |-> (pslverr == (paddr > 8'h10)); endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_err_rd; pready && !pwrite && (paddr > 8'h10) |-> (prdata == 32'h0); endproperty
  a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
  property p_bit1; pready && !pwrite && (paddr == 8'h00) |-> !prdata[1]; endproperty
  a_bit1: assert property (p_bit1) else $error("control bit 1 reads one");
  property p_osc_on;
    $rose(crystal_osc_on) |-> $past(wr_acc && paddr == 8'h00 && pwdata[3], 1)
      || $past(wr_acc && paddr == 8'h00 && pwdata[3], 2);
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator on without write");
  property p_xtal_off; !crystal_osc_on && $past(!crystal_osc_on) |-> !crystal_out_pin; endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("crystal driven while off");
  property p_roll_clr; $fell(rollover_flag) |-> $past(fl_wr && pwdata[0]); endproperty
  a_roll_clr: assert property (p_roll_clr) else $error("rollover flag lost");
  property p_gev_clr; $fell(gate_event_flag) |-> $past(fl_wr && pwdata[1]); endproperty
  a_gev_clr: assert property (p_gev_clr) else $error("gate event flag lost");

  c_roll: cover property ($rose(rollover_flag));
  c_gev: cover property ($rose(gate_event_flag));
  c_err: cover property (pready && pslverr);
endmodule : gtm_timer_monitor

// ==== dv/gtm_src_model.sv ====
/*
  Model of the count clock, crystal and gate sources around the timer.
  Assumes pclk paces every source; the count pin stands still when idle.
*/
`timescale 1ns/1ns
module gtm_src_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ext_run,
  input  wire logic       osc_on,
  input  wire logic [3:0] gate_cmd,
  output logic            ext_count_input,
  output logic            crystal_in_pin,
  output logic            low_freq_internal_oscillator,
  output logic            gate_pin,
  output logic            tmr8_overflow,
  output logic            cmp_a_output,
  output logic            cmp_b_output
);
  int cyc;
  // Count pin period 6, crystal period 10, slow oscillator period 14.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc                          <= 0;
      ext_count_input              <= 1'b0;
      crystal_in_pin               <= 1'b0;
      low_freq_internal_oscillator <= 1'b0;
    end else begin
      cyc <= (cyc == 209) ? 0 : cyc + 1;
      if (ext_run && cyc % 3 == 0) ext_count_input <= ~ext_count_input;
      if (osc_on && cyc % 5 == 0) crystal_in_pin <= ~crystal_in_pin;
      if (cyc % 7 == 0) low_freq_internal_oscillator <= ~low_freq_internal_oscillator;
    end
  end
  // Each gate source follows its own command bit.
  assign {cmp_b_output, cmp_a_output, tmr8_overflow, gate_pin} = gate_cmd;
endmodule : gtm_src_model

// ==== dv/testbench.sv ====
/*
  Self-checking bench for the gated timer over APB.
  Assumes the source model drives every count and gate input.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h, expected %h", $time, (a), (b)); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, ext_run, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, xin, xout, xon, lfo, gpin, t8, ca, cb, ext, rof, gef;
  logic [3:0]  gcmd;
  logic [15:0] cv, pv;
  int          n_errors, checks_done;
  logic [7:0]  ctl [9] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h00, 8'hC0, 8'h80, 8'h84, 8'h88};
  int          ex [9] = '{120, 60, 30, 15, 30, 8, 20, 20, 12};

  // Instance one keeps the oscillator option.
  gtm_timer #(.HAS_OSC(1'b1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_input(ext), .crystal_in_pin(xin),
    .low_freq_internal_oscillator(lfo), .gate_pin(gpin), .tmr8_overflow(t8),
    .cmp_a_output(ca), .cmp_b_output(cb), .crystal_out_pin(xout), .crystal_osc_on(xon),
    .rollover_flag(rof), .gate_event_flag(gef));
  gtm_src_model u_src (.pclk(pclk), .presetn(presetn), .ext_run(ext_run), .osc_on(xon),
    .gate_cmd(gcmd), .ext_count_input(ext), .crystal_in_pin(xin),
    .low_freq_internal_oscillator(lfo), .gate_pin(gpin), .tmr8_overflow(t8),
    .cmp_a_output(ca), .cmp_b_output(cb));

  // ----------------------------------------------------------------------
  // Bus and helper tasks.
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rv[7:0] & m, e)
  endtask : rdc

  task automatic cnt(input int lo, input int hi);
    apb(1'b0, gtm_pkg::OFS_COUNT_LOW, 32'h0);
    cv[7:0] = rv[7:0];
    apb(1'b0, gtm_pkg::OFS_COUNT_HIGH, 32'h0);
    cv[15:8] = rv[7:0];
    `CHK((cv >= lo) && (cv <= hi), 1'b1)
  endtask : cnt

  task automatic run(input logic [7:0] c);
    apb(1'b1, gtm_pkg::OFS_COUNT_LOW, 32'h0);
    apb(1'b1, gtm_pkg::OFS_COUNT_HIGH, 32'h0);
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, {24'h0, c | 8'h01});
    repeat (118) @(posedge pclk);
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, {24'h0, c});
  endtask : run

  task automatic gate(input logic [3:0] g, input int n);
    @(posedge pclk);
    gcmd <= g;
    repeat (n) @(posedge pclk);
  endtask : gate

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rdc(gtm_pkg::OFS_TIMER_CONTROL, 8'hFF, 8'h00);
    rdc(gtm_pkg::OFS_GATE_CONTROL, 8'hFB, 8'h00);
    rdc(gtm_pkg::OFS_COUNT_HIGH, 8'hFF, 8'h00);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({re, rv}, {1'b1, 32'h0})
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'hFF);
    rdc(gtm_pkg::OFS_TIMER_CONTROL, 8'hFF, 8'hFD);
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'hC3);
    rdc(gtm_pkg::OFS_GATE_CONTROL, 8'hFB, 8'hC3);
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'h0);
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h0);
  endtask : t_reset

  task automatic t_clock();
    ext_run <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      run(ctl[i]);
      cnt(ex[i] - 2, ex[i] + 2);
    end
    repeat (2) @(negedge pclk);
    `CHK(xon, 1'b1)
    pv[0] = xout;
    repeat (5) @(negedge pclk);
    `CHK(xout, ~pv[0])
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h0);
    repeat (2) @(negedge pclk);
    `CHK({xon, xout}, 2'h0)
  endtask : t_clock

  task automatic t_gate();
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'hC0);
    run(8'h40);
    cnt(0, 0);
    gate(4'h1, 4);
    run(8'h40);
    cnt(118, 122);
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'h80);
    gate(4'h0, 4);
    run(8'h40);
    cnt(118, 122);
    repeat (50) @(posedge pclk);
    cnt(cv, cv);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'h40 | k);
      gate(4'h1 << k, 6);
      rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h04, 8'h04);
      gate(4'hF ^ (4'h1 << k), 6);
      rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h04, 8'h00);
    end
  endtask : t_gate

  task automatic t_flags();
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'h40);
    apb(1'b1, gtm_pkg::OFS_FLAGS, 32'h2);
    gate(4'h1, 6);
    `CHK(gef, 1'b0)
    gate(4'h0, 6);
    `CHK(gef, 1'b1)
    apb(1'b1, gtm_pkg::OFS_FLAGS, 32'h2);
    @(negedge pclk);
    `CHK(gef, 1'b0)
    apb(1'b1, gtm_pkg::OFS_COUNT_LOW, 32'hF0);
    apb(1'b1, gtm_pkg::OFS_COUNT_HIGH, 32'hFF);
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h41);
    repeat (30) @(posedge pclk);
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h40);
    `CHK(rof, 1'b1)
    rdc(gtm_pkg::OFS_COUNT_HIGH, 8'hFF, 8'h00);
    apb(1'b1, gtm_pkg::OFS_FLAGS, 32'h1);
    @(negedge pclk);
    `CHK(rof, 1'b0)
  endtask : t_flags

  task automatic t_modes();
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h41);
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'h60);
    for (int k = 0; k < 3; k++) begin
      gate(4'h1, 6);
      gate(4'h0, 6);
      rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h04, (k == 1) ? 8'h00 : 8'h04);
    end
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h40);
    rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h04, 8'h00);
    apb(1'b1, gtm_pkg::OFS_COUNT_LOW, 32'h0);
    apb(1'b1, gtm_pkg::OFS_COUNT_HIGH, 32'h0);
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'hD8);
    apb(1'b1, gtm_pkg::OFS_TIMER_CONTROL, 32'h41);
    rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h08, 8'h08);
    apb(1'b1, gtm_pkg::OFS_GATE_CONTROL, 32'hD0);
    rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h08, 8'h08);
    cnt(0, 0);
    gate(4'h1, 40);
    gate(4'h0, 6);
    rdc(gtm_pkg::OFS_GATE_CONTROL, 8'h08, 8'h00);
    cnt(36, 46);
    pv = cv;
    gate(4'h1, 40);
    gate(4'h0, 6);
    cnt(pv, pv);
  endtask : t_modes

  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    {psel, penable, pwrite, ext_run, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    gcmd = 4'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clock();
    t_gate();
    t_flags();
    t_modes();
    end_of_test();
  end

  // Watchdog well past the expected run length.
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule : testbench

bind gtm_timer gtm_timer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_count_input(ext_count_input),
  .crystal_in_pin(crystal_in_pin), .gate_pin(gate_pin),
  .low_freq_internal_oscillator(low_freq_internal_oscillator),
  .tmr8_overflow(tmr8_overflow), .cmp_a_output(cmp_a_output), .cmp_b_output(cmp_b_output),
  .crystal_out_pin(crystal_out_pin), .crystal_osc_on(crystal_osc_on),
  .rollover_flag(rollover_flag), .gate_event_flag(gate_event_flag));
